// [design/ncl_logic_ops.sv]
// Execution unit for accumulator logic, rotate, increment, pair loads.
// Assumes program memory answers o_rom_addr in the same clock.
//
// Contract
// (RULE_01) AND with register: result and carry
// (RULE_02) ROM operand uses high or low nibble
// (RULE_03) AND immediate from second word
// (RULE_04) OR stores result, clears carry
// (RULE_05) XOR stores result, carry from bit 3s
// (RULE_06) Increment; carry set when result zero
// (RULE_07) Rotate toward MSB; carry gets bit 3
// (RULE_08) Rotate-or-reset resets on zero accumulator
// (RULE_09) Port pair loaded from immediate byte
// (RULE_10) Register pair loaded from byte or ROM
// (RULE_11) Four-bit datapath, one instruction cycle each
// (RULE_12) One bit selects bank or nibble
// (RULE_13) ROM address from page and pair zero
// (RULE_14) Call overflow causes internal reset
// (RULE_15) Return underflow causes internal reset
`timescale 1ns/1ps
`default_nettype none
`include "ncl_defs.svh"

module ncl_logic_ops
  import ncl_pkg::*;
#(
  parameter int SP_W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [9:0] i_instr,
  input wire logic [9:0] i_operand,
  input wire logic [9:0] i_pc,
  input wire logic [9:0] i_rom_data,
  output logic [9:0] o_rom_addr,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [3:0] o_acc,
  output logic o_carry,
  output ncl_ports_s o_ports,
  output logic o_pc_load,
  output logic [9:0] o_pc_value,
  output logic o_internal_reset
);

  generate
    if (SP_W < 1 || SP_W > 4) begin : g_bad_sp
      $error("Stack pointer width out of range");
    end
  endgenerate

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  function automatic ncl_dec_s decode(input logic [9:0] w);
    ncl_dec_s d;
    d.kind = NCL_K_NONE;
    d.op = NCL_OP_AND;
    d.low_sel = w[5]; // RULE_12
    d.idx = w[3:0];
    if (w[9:6] == `NCL_CLASS_AND || w[9:6] == `NCL_CLASS_OR ||
        w[9:6] == `NCL_CLASS_XOR) begin
      if (w[9:6] == `NCL_CLASS_AND) begin
        d.op = NCL_OP_AND;
      end else if (w[9:6] == `NCL_CLASS_OR) begin
        d.op = NCL_OP_OR;
      end else begin
        d.op = NCL_OP_XOR;
      end
      if (!w[4]) begin
        d.kind = NCL_K_LOGIC_REG;
      end else if (w[3:0] == `NCL_LOW_ROM) begin
        d.kind = NCL_K_LOGIC_ROM;
      end else if (w[3:0] == `NCL_LOW_IMM) begin
        d.kind = NCL_K_LOGIC_IMM;
      end
    end
    if (w == `NCL_CODE_INC) begin
      d.kind = NCL_K_INC;
    end else if (w == `NCL_CODE_ROT) begin
      d.kind = NCL_K_ROT;
    end else if (w == `NCL_CODE_ROTZ) begin
      d.kind = NCL_K_ROTZ;
    end else if (w == `NCL_CODE_CALL) begin
      d.kind = NCL_K_CALL;
    end else if (w == `NCL_CODE_RET) begin
      d.kind = NCL_K_RET;
    end else if (w[9:3] == `NCL_PFX_OUT_IMM) begin
      if (w[2:0] == 3'h0 || w[2:0] == 3'h1 || w[2:0] == 3'h3 ||
          w[2:0] == 3'h4) begin
        d.kind = NCL_K_OUT_IMM;
      end
    end else if (w[9:4] == `NCL_PFX_PAIR_IMM) begin
      d.kind = NCL_K_PAIR_IMM;
    end else if (w[9:4] == `NCL_PFX_PAIR_ROM && w[3:0] != 4'h0) begin
      d.kind = NCL_K_PAIR_ROM;
    end
    return d;
  endfunction

  // Result nibble in [3:0], carry in [4]
  function automatic logic [4:0] logic_op(input ncl_op_e op,
                                          input logic [3:0] a,
                                          input logic [3:0] b);
    logic [4:0] r;
    r = 5'h00;
    unique case (op)
      NCL_OP_AND: r = {a[3] & b[3], a & b}; // RULE_01 RULE_03
      NCL_OP_OR: r = {1'b0, a | b}; // RULE_04
      NCL_OP_XOR: r = {a[3] & b[3], a ^ b}; // RULE_05
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // Pair read for an instruction: its own pair, else pair zero for ROM
  function automatic logic [3:0] op_pair(input ncl_dec_s d);
    return (d.kind == NCL_K_LOGIC_REG) ? d.idx : 4'h0;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ncl_state_e state;
  ncl_dec_s dec;
  ncl_dec_s in_dec;
  logic [9:0] operand;
  logic [3:0] acc;
  logic carry;
  ncl_ports_s ports;
  logic [SP_W-1:0] sp;
  logic [9:0] saved_return_address;
  logic [7:0] rd_data;
  logic [3:0] rd_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [3:0] nib;
  logic [4:0] alu;
  logic [1:0] page;
  logic exec;

  assign in_dec = decode(i_instr);
  assign exec = (state == NCL_S_EXEC);
  assign page = ports.p3[5:4]; // RULE_13
  // Pair zero feeds the ROM address; a register operand reads its pair.
  // Once taken, the latched word steers the read, so i_instr may move on.
  assign rd_addr = (state == NCL_S_IDLE) ? op_pair(in_dec) : op_pair(dec);

  ncl_pair_mem #(.ADDR_W(4), .DATA_W(8)) u_mem (
    .i_clk(i_clk),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data),
    .i_wr_en(wr_en),
    .i_wr_addr(dec.idx),
    .i_wr_data(wr_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= NCL_S_IDLE;
    end else begin
      unique case (state)
        NCL_S_IDLE: begin
          if (i_start) begin
            state <= NCL_S_FETCH;
          end
        end
        NCL_S_FETCH: state <= NCL_S_EXEC;
        NCL_S_EXEC: state <= NCL_S_IDLE; // RULE_11
        default: state <= NCL_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dec <= '0;
      operand <= 10'h000;
    end else if (state == NCL_S_IDLE && i_start) begin
      dec <= in_dec;
      operand <= i_operand;
    end
  end

  // The ROM is addressed one edge after the pair read returns
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rom_addr <= 10'h000;
    end else if (state == NCL_S_FETCH) begin
      o_rom_addr <= {page, rd_data}; // RULE_13
    end
  end

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  always_comb begin
    unique case (dec.kind)
      NCL_K_LOGIC_REG: nib = dec.low_sel ? rd_data[3:0] : rd_data[7:4];
      NCL_K_LOGIC_ROM: begin
        nib = dec.low_sel ? i_rom_data[3:0] : i_rom_data[7:4]; // RULE_02
      end
      default: nib = operand[3:0];
    endcase
  end

  assign alu = logic_op(dec.op, acc, nib);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc <= `NCL_RST_ACC;
      carry <= 1'b0;
    end else if (exec) begin
      unique case (dec.kind)
        NCL_K_LOGIC_REG, NCL_K_LOGIC_ROM, NCL_K_LOGIC_IMM: begin
          acc <= alu[3:0];
          carry <= alu[4];
        end
        NCL_K_INC: begin
          acc <= 4'(acc + 4'h1); // RULE_06
          carry <= (acc == 4'hF);
        end
        NCL_K_ROT, NCL_K_ROTZ: begin
          if (!(dec.kind == NCL_K_ROTZ && acc == 4'h0)) begin
            acc <= {acc[2:0], acc[3]}; // RULE_07 RULE_08
            carry <= acc[3];
          end
        end
        default: begin
          acc <= acc;
          carry <= carry;
        end
      endcase
    end
  end

  // Pair writes: upper nibble to the upper bank, lower to the lower
  assign wr_en = exec &&
    (dec.kind == NCL_K_PAIR_IMM || dec.kind == NCL_K_PAIR_ROM);
  assign wr_data = (dec.kind == NCL_K_PAIR_ROM) ? i_rom_data[7:0] :
                   operand[7:0]; // RULE_10

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ports <= {4{`NCL_RST_PORT}};
    end else if (exec && dec.kind == NCL_K_OUT_IMM) begin
      unique case (dec.idx[2:0])
        3'h0: ports.p0 <= operand[7:0]; // RULE_09
        3'h1: ports.p1 <= operand[7:0];
        3'h3: ports.p3 <= operand[7:0];
        default: ports.p4 <= operand[7:0];
      endcase
    end
  end

  // ------------------------------------------------------------
  // Stack and internal reset
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sp <= '0;
      saved_return_address <= `NCL_RST_ASR;
      o_pc_load <= 1'b0;
      o_pc_value <= 10'h000;
      o_internal_reset <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_pc_load <= exec && (dec.kind == NCL_K_CALL ||
                            dec.kind == NCL_K_RET);
      o_illegal <= exec && dec.kind == NCL_K_NONE;
      o_internal_reset <= 1'b0;
      if (exec && dec.kind == NCL_K_CALL) begin
        sp <= SP_W'(sp + 1'b1);
        saved_return_address <= i_pc;
        o_pc_value <= operand;
        o_internal_reset <= (sp == {SP_W{1'b1}}); // RULE_14
      end else if (exec && dec.kind == NCL_K_RET) begin
        o_pc_value <= saved_return_address;
        sp <= SP_W'(sp - 1'b1);
        o_internal_reset <= (sp == '0); // RULE_15
      end else if (exec && dec.kind == NCL_K_ROTZ) begin
        o_internal_reset <= (acc == 4'h0); // RULE_08
      end
    end
  end

  assign o_busy = (state != NCL_S_IDLE);
  assign o_done = exec;
  assign o_acc = acc;
  assign o_carry = carry;
  assign o_ports = ports;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_accept;
    state == NCL_S_IDLE && i_start;
  endsequence
  sequence s_walk;
    state == NCL_S_FETCH ##1 state == NCL_S_EXEC ##1 state == NCL_S_IDLE;
  endsequence

  a_cycle_walk: assert property (s_accept |=> s_walk) // RULE_11
    else $error("Instruction did not finish in three clocks");
  a_and_reg: assert property (exec && dec.kind == NCL_K_LOGIC_REG &&
      dec.op == NCL_OP_AND |=> acc == ($past(acc) & $past(nib)) &&
      carry == ($past(acc[3]) & $past(nib[3]))) // RULE_01
    else $error("AND with register wrong");
  a_rom_nibble: assert property (exec && dec.kind == NCL_K_LOGIC_ROM &&
      dec.op == NCL_OP_AND |=> acc == ($past(acc) & ($past(dec.low_sel) ?
      $past(i_rom_data[3:0]) : $past(i_rom_data[7:4]))) &&
      carry == ($past(acc[3]) & ($past(dec.low_sel) ?
      $past(i_rom_data[3]) : $past(i_rom_data[7])))) // RULE_02
    else $error("Wrong ROM nibble used");
  a_and_imm: assert property (exec && dec.kind == NCL_K_LOGIC_IMM &&
      dec.op == NCL_OP_AND |=> acc == ($past(acc) & $past(operand[3:0])) &&
      carry == ($past(acc[3]) & $past(operand[3]))) // RULE_03
    else $error("AND immediate wrong");
  a_or_clear: assert property (exec && dec.op == NCL_OP_OR &&
      (dec.kind == NCL_K_LOGIC_REG || dec.kind == NCL_K_LOGIC_ROM ||
      dec.kind == NCL_K_LOGIC_IMM) |=> !carry &&
      acc == ($past(acc) | $past(nib))) // RULE_04
    else $error("OR result or carry wrong");
  a_xor_carry: assert property (exec && dec.op == NCL_OP_XOR &&
      dec.kind == NCL_K_LOGIC_REG |=> acc == ($past(acc) ^ $past(nib)) &&
      carry == ($past(acc[3]) & $past(nib[3]))) // RULE_05
    else $error("XOR result or carry wrong");
  a_inc_wrap: assert property (exec && dec.kind == NCL_K_INC
      |=> acc == 4'($past(acc) + 4'h1) && carry == (acc == 4'h0)) // RULE_06
    else $error("Increment wrong");
  a_rotate_msb: assert property (exec && dec.kind == NCL_K_ROT
      |=> acc == {$past(acc[2:0]), $past(acc[3])} &&
      carry == $past(acc[3])) // RULE_07
    else $error("Rotate wrong");
  a_rotz_reset: assert property (exec && dec.kind == NCL_K_ROTZ
      |=> o_internal_reset == ($past(acc) == 4'h0)) // RULE_08
    else $error("Rotate-or-reset did not match zero test");
  a_port_load: assert property (exec && dec.kind == NCL_K_OUT_IMM &&
      dec.idx[2:0] == 3'h3 |=> o_ports.p3 == $past(operand[7:0])) // RULE_09
    else $error("Port pair not loaded");
  a_pair_write: assert property (exec && dec.kind == NCL_K_PAIR_IMM
      |-> wr_en && wr_data == operand[7:0]) // RULE_10
    else $error("Pair write missing");
  a_rom_addr: assert property (state == NCL_S_FETCH
      |=> o_rom_addr == {$past(page), $past(rd_data)}) // RULE_13
    else $error("ROM address not formed from page and pair");
  a_call_over: assert property (exec && dec.kind == NCL_K_CALL &&
      sp == {SP_W{1'b1}} |=> o_internal_reset && o_pc_load) // RULE_14
    else $error("Stack overflow not reset");
  a_ret_under: assert property (exec && dec.kind == NCL_K_RET &&
      sp == '0 |=> o_internal_reset && o_pc_value == $past(saved_return_address)) // RULE_15
    else $error("Stack underflow not reset");

endmodule

`default_nettype wire

// [common/ncl_defs.svh]
// Constants for the nibble logic-operation execution unit.
// Assumes 10-bit instruction words; included by the design and testbench files.
`ifndef NCL_DEFS_SVH
`define NCL_DEFS_SVH

// ------------------------------------------------------------
// Instruction fields (bit 9 down to bit 0)
// ------------------------------------------------------------
`define NCL_CLASS_AND 4'hD
`define NCL_CLASS_OR 4'hE
`define NCL_CLASS_XOR 4'hA
`define NCL_LOW_ROM 4'h0
`define NCL_LOW_IMM 4'h1
`define NCL_CODE_INC 10'h293
`define NCL_CODE_ROT 10'h393
`define NCL_CODE_ROTZ 10'h3D3
`define NCL_CODE_CALL 10'h0D2
`define NCL_CODE_RET 10'h112
`define NCL_PFX_OUT_IMM 7'h1B
`define NCL_PFX_PAIR_IMM 6'h0C
`define NCL_PFX_PAIR_ROM 6'h0E

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define NCL_RST_ACC 4'h0
`define NCL_RST_PORT 8'h00
`define NCL_RST_ASR 10'h000

`endif

// [common/ncl_pkg.sv]
// Types shared by the nibble logic-operation execution unit.
// Assumes ncl_defs.svh sits on the include path.
package ncl_pkg;

  typedef enum logic [3:0] {
    NCL_K_NONE = 4'h0,
    NCL_K_LOGIC_REG = 4'h1,
    NCL_K_LOGIC_ROM = 4'h2,
    NCL_K_LOGIC_IMM = 4'h3,
    NCL_K_INC = 4'h4,
    NCL_K_ROT = 4'h5,
    NCL_K_ROTZ = 4'h6,
    NCL_K_OUT_IMM = 4'h7,
    NCL_K_PAIR_IMM = 4'h8,
    NCL_K_PAIR_ROM = 4'h9,
    NCL_K_CALL = 4'hA,
    NCL_K_RET = 4'hB
  } ncl_kind_e;

  typedef enum logic [1:0] {
    NCL_OP_AND = 2'h0,
    NCL_OP_OR = 2'h1,
    NCL_OP_XOR = 2'h2
  } ncl_op_e;

  typedef enum logic [1:0] {
    NCL_S_IDLE = 2'b00,
    NCL_S_FETCH = 2'b01,
    NCL_S_EXEC = 2'b11
  } ncl_state_e;

  typedef struct packed {
    ncl_kind_e kind;
    ncl_op_e op;
    logic low_sel;
    logic [3:0] idx;
  } ncl_dec_s;

  typedef struct packed {
    logic [7:0] p4;
    logic [7:0] p3;
    logic [7:0] p1;
    logic [7:0] p0;
  } ncl_ports_s;

endpackage

// [design/ncl_pair_mem.sv]
// Register-pair data memory: each word is an upper/lower nibble pair.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module ncl_pair_mem #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  input wire logic i_clk,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  generate
    if (DATA_W % 2 != 0) begin : g_bad_width
      $error("Pair width must be even");
    end
  endgenerate

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rd_data <= mem[i_rd_addr];
  end

endmodule

`default_nettype wire

// [testbench/ncl_rom_model.sv]
// Program memory model seen by the logic-operation unit.
// Assumes a combinational read of the word at the given address.
`timescale 1ns/1ps
`default_nettype none

module ncl_rom_model (
  input wire logic [9:0] i_addr,
  output logic [9:0] o_data
);
  // ----------------------------------------------------------
  // Contents
  // ----------------------------------------------------------
  // A pattern unlike the address itself, so a wrong page or pair shows
  assign o_data = i_addr ^ 10'h2A5;
endmodule

`default_nettype wire

// [testbench/ncl_logic_ops_tb.sv]
// Self-checking bench for the nibble logic-operation unit.
// Assumes the program memory model and the unit's package and defines.
`timescale 1ns/1ps
`default_nettype none
`include "ncl_defs.svh"

module ncl_logic_ops_tb;
  import ncl_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  logic [9:0] i_instr = 10'h000;
  logic [9:0] i_operand = 10'h000;
  logic [9:0] i_pc = 10'h123;
  logic [9:0] i_rom_data, o_rom_addr, o_pc_value;
  logic o_busy, o_done, o_illegal, o_carry, o_pc_load, o_internal_reset;
  logic [3:0] o_acc;
  ncl_ports_s o_ports;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] pairs [16];
  ncl_ports_s e_ports = '0;
  logic [3:0] e_acc = 4'h0;
  logic e_car = 1'b0;
  logic e_sp = 1'b0;
  logic [9:0] e_asr = 10'h000;
  logic [9:0] e_pcv = 10'h000;

  always #25 i_clk = ~i_clk;

  ncl_logic_ops #(.SP_W(1)) i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
    .i_instr(i_instr), .i_operand(i_operand), .i_pc(i_pc),
    .i_rom_data(i_rom_data), .o_rom_addr(o_rom_addr), .o_busy(o_busy),
    .o_done(o_done), .o_illegal(o_illegal), .o_acc(o_acc),
    .o_carry(o_carry), .o_ports(o_ports), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_internal_reset(o_internal_reset)
  );

  ncl_rom_model i_rom (.i_addr(o_rom_addr), .o_data(i_rom_data));

  // ----------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // Hang guard: a whole run needs under two hundred cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------
  // One instruction, predicted and judged
  // ----------------------------------------------------------
  task automatic op(input logic [9:0] ins, input logic [9:0] opd);
    logic [9:0] a;
    logic [9:0] w;
    logic [7:0] p;
    logic [3:0] b;
    logic rst, pcl, ill, use_rom;
    a = {e_ports.p3[5:4], pairs[0]};
    w = a ^ 10'h2A5;
    p = pairs[ins[3:0]];
    b = ins[5] ? p[3:0] : p[7:4];
    use_rom = ins[4] && ins[3:0] == 4'h0;
    if (ins[4]) b = ins[0] ? opd[3:0] : (ins[5] ? w[3:0] : w[7:4]);
    rst = 1'b0;
    pcl = 1'b0;
    ill = 1'b0;
    if (ins == `NCL_CODE_INC) begin
      e_acc = e_acc + 4'h1;
      e_car = e_acc == 4'h0;
    end else if (ins == `NCL_CODE_ROT ||
                 (ins == `NCL_CODE_ROTZ && e_acc != 4'h0)) begin
      e_car = e_acc[3];
      e_acc = {e_acc[2:0], e_acc[3]};
    end else if (ins == `NCL_CODE_ROTZ) begin
      rst = 1'b1;
    end else if (ins == `NCL_CODE_CALL) begin
      rst = e_sp;
      e_sp = e_sp + 1'b1;
      e_asr = i_pc;
      e_pcv = opd;
      pcl = 1'b1;
    end else if (ins == `NCL_CODE_RET) begin
      rst = !e_sp;
      e_sp = e_sp - 1'b1;
      e_pcv = e_asr;
      pcl = 1'b1;
    end else if (ins == 10'h0E0) begin
      ill = 1'b1;
    end else if (ins[9:4] == `NCL_PFX_PAIR_IMM) begin
      pairs[ins[3:0]] = opd[7:0];
      use_rom = 1'b0;
    end else if (ins[9:4] == `NCL_PFX_PAIR_ROM) begin
      pairs[ins[3:0]] = w[7:0];
      use_rom = 1'b1;
    end else if (ins[9:3] == `NCL_PFX_OUT_IMM) begin
      case (ins[2:0])
        3'h0: e_ports.p0 = opd[7:0];
        3'h1: e_ports.p1 = opd[7:0];
        3'h3: e_ports.p3 = opd[7:0];
        default: e_ports.p4 = opd[7:0];
      endcase
    end else if (ins[9:6] == `NCL_CLASS_OR) begin
      e_acc = e_acc | b;
      e_car = 1'b0;
    end else begin
      e_car = e_acc[3] & b[3];
      e_acc = ins[9:6] == `NCL_CLASS_AND ? e_acc & b : e_acc ^ b;
    end
    @(negedge i_clk);
    i_start = 1'b1;
    i_instr = ins;
    i_operand = opd;
    @(negedge i_clk);
    i_start = 1'b0;
    chk(o_busy, 1);
    @(negedge i_clk);
    chk(o_done, 1);
    if (use_rom) chk(o_rom_addr, a);
    @(negedge i_clk);
    chk(o_acc, e_acc);
    chk(o_carry, e_car);
    chk(o_ports, e_ports);
    chk(o_internal_reset, rst);
    chk(o_pc_load, pcl);
    if (pcl) chk(o_pc_value, e_pcv);
    chk(o_illegal, ill);
    chk(o_busy, 0);
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_setup;
    int n [4] = '{0, 1, 3, 4};
    op(10'h0C0, 10'h09A);
    op(10'h0C5, 10'h03C);
    foreach (n[k]) op(10'h0D8 + 10'(n[k]), {2'b00, 4'(n[k] + 8), 4'hC});
  endtask

  task automatic t_logic;
    logic [3:0] cls [3] = '{`NCL_CLASS_AND, `NCL_CLASS_OR, `NCL_CLASS_XOR};
    logic [5:0] form [5] = '{6'h00, 6'h25, 6'h10, 6'h30, 6'h31};
    foreach (cls[c]) begin
      op(10'h3B1, 10'h00F);
      foreach (form[f]) op({cls[c], form[f]}, 10'(f * 3 + 7));
    end
  endtask

  task automatic t_incrot;
    logic [9:0] seq [11] = '{10'h3B1, `NCL_CODE_INC, `NCL_CODE_INC,
      `NCL_CODE_ROT, 10'h3B1, `NCL_CODE_ROT, 10'h371, `NCL_CODE_ROTZ,
      10'h3B1, `NCL_CODE_ROTZ, `NCL_CODE_ROTZ};
    logic [9:0] imm [11] = '{10'h00F, 0, 0, 0, 10'h008, 0, 10'h000, 0,
      10'h004, 0, 0};
    foreach (seq[k]) op(seq[k], imm[k]);
  endtask

  task automatic t_stack;
    op(`NCL_CODE_CALL, 10'h2E7);
    op(`NCL_CODE_RET, 10'h000);
    op(`NCL_CODE_RET, 10'h000);
    op(`NCL_CODE_CALL, 10'h155);
  endtask

  task automatic t_pairrom;
    op(10'h0E7, 10'h000);
    op(10'h3B1, 10'h00F);
    op(10'h367, 10'h000);
    op(10'h0E0, 10'h000);
  endtask

  initial begin
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    t_setup();
    t_logic();
    t_incrot();
    t_stack();
    t_pairrom();
    stop_test();
  end
endmodule

`default_nettype wire
